// ==== rtl/sbts_pkg.sv ====
/*
  shared constants and types of the block transfer session controller:
  register offsets, command and status bit positions, tlv framing values.
  assumes it is compiled before every other design file.
*/
package sbts_pkg;

  // register offsets of the controller's own port
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BLOCKS = 8'h04;
  localparam logic [7:0] A_LEN = 8'h08;
  localparam logic [7:0] A_TXDATA = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_SW = 8'h14;
  localparam logic [7:0] A_RXDATA = 8'h18;
  localparam logic [7:0] A_SESS = 8'h1c;

  // control register fields
  localparam int C_SESS_LO = 0;
  localparam int C_DIR = 2;
  localparam int C_ABORT = 3;
  localparam int C_RTX = 4;

  // status register fields
  localparam int S_BUSY = 0;
  localparam int S_ERR_CMD = 1;
  localparam int S_ERR_TLV = 2;
  localparam int S_MORE = 3;
  localparam int S_PROACT = 4;
  localparam int S_RESEND = 5;
  localparam int S_CARD_ABORT = 6;
  localparam int S_PEND_LO = 7;

  // first parameter byte fields
  localparam int P1_SESS_LO = 6;
  localparam int P1_DATA = 2;
  localparam int P1_ABORT = 1;
  localparam int P1_RTX = 0;

  // second status byte fields
  localparam int SW2_RTX = 4;
  localparam int SW2_PRO = 3;
  localparam int SW2_SESS_LO = 1;
  localparam int SW2_MORE = 0;

  // status words
  localparam logic [7:0] SW1_ONGOING = 8'h92;
  localparam logic [7:0] SW1_PROACT = 8'h91;
  localparam logic [15:0] SW_NOMEM = 16'h6a84;

  // tlv framing
  localparam logic [7:0] TAG_SCD = 8'h80;
  localparam logic [7:0] LEN_SHORT_MAX = 8'h7f;
  localparam logic [7:0] LEN_EXT = 8'h81;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOOK, ST_CHECK, ST_TAG, ST_LEXT, ST_LEN, ST_VAL, ST_WAIT
  } sbts_state_e;

  typedef struct packed {
    logic active;
    logic pending;
    logic [7:0] tag;
    logic [7:0] remaining;
  } sbts_sess_s;

  // number of length bytes for a value length
  function automatic logic [1:0] sbts_len_hdr(input logic [7:0] len);
    return (len > LEN_SHORT_MAX) ? 2'h2 : 2'h1;
  endfunction : sbts_len_hdr

endpackage : sbts_pkg

// ==== rtl/sbts_sess_mem.sv ====
/*
  per-session state store: four entries, one write port, registered read.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module sbts_sess_mem (
  input wire logic clock,
  input wire logic rst,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire sbts_pkg::sbts_sess_s wdata,
  input wire logic [1:0] raddr,
  output sbts_pkg::sbts_sess_s rdata
);

  typedef struct packed {
    sbts_pkg::sbts_sess_s [3:0] ent;
    sbts_pkg::sbts_sess_s rd;
  } sbts_mem_s;

  sbts_mem_s q;
  sbts_mem_s next_q;

  // read first, returns the old contents on a same-cycle write
  always_comb begin
    next_q = q;
    next_q.rd = q.ent[raddr];
    if (we) begin
      next_q.ent[waddr] = wdata;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rd;

endmodule : sbts_sess_mem

// ==== rtl/sbts_tlv_rx.sv ====
/*
  checker for response tlv framing: tag, one or two length bytes, value count.
  assumes bytes arrive on the controller clock, one per valid cycle.
*/
`timescale 1ns/100ps
module sbts_tlv_rx (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic tag_err,
  output logic [7:0] cnt,
  output logic [7:0] last
);

  typedef enum logic [1:0] {RX_TAG, RX_L1, RX_L2, RX_VAL} sbts_rx_e;

  typedef struct packed {
    sbts_rx_e st;
    logic err;
    logic [7:0] len;
    logic [7:0] cnt;
    logic [7:0] last;
  } sbts_rx_s;

  sbts_rx_s q;
  sbts_rx_s next_q;

  // walk tag, length and value bytes
  always_comb begin
    next_q = q;
    if (clear) begin
      next_q = '0;
    end else if (rx_valid) begin
      unique case (q.st)
        RX_TAG: begin
          next_q.err = q.err | (rx_byte != sbts_pkg::TAG_SCD);
          next_q.st = RX_L1;
        end
        RX_L1: begin
          if (rx_byte == sbts_pkg::LEN_EXT) begin
            next_q.st = RX_L2;
          end else begin
            next_q.err = q.err | (rx_byte > sbts_pkg::LEN_SHORT_MAX);
            next_q.len = rx_byte;
            next_q.st = RX_VAL;
          end
        end
        RX_L2: begin
          next_q.err = q.err | (rx_byte <= sbts_pkg::LEN_SHORT_MAX);
          next_q.len = rx_byte;
          next_q.st = RX_VAL;
        end
        RX_VAL: begin
          next_q.err = q.err | (q.cnt == q.len);
          next_q.cnt = q.cnt + 8'h01;
          next_q.last = rx_byte;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tag_err = q.err;
  assign cnt = q.cnt;
  assign last = q.last;

endmodule : sbts_tlv_rx

// ==== rtl/sbts_host.sv ====
/*
  terminal-side controller for interleaved bulk transfer sessions: builds the
  command parameters and tlv framing, sends value bytes as software writes
  them, decodes the card's status words and keeps per-session state.
  assumes the card link runs on this clock and never stalls a byte, and that
  the card answers each command with exactly one rsp_valid pulse.
*/
`timescale 1ns/100ps

module sbts_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [15:0] rdata,
  output logic cmd_start,
  output logic [7:0] cmd_p1,
  output logic [7:0] cmd_p2,
  output logic [8:0] cmd_len,
  output logic cmd_has_lc,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_sw1,
  input wire logic [7:0] rsp_sw2
);

  typedef struct packed {
    sbts_pkg::sbts_state_e st;
    logic [1:0] sess;
    logic dir;
    logic abrt;
    logic rtx;
    logic [7:0] blocks;
    logic [7:0] len;
    logic [7:0] cnt;
    logic cmd_start;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [8:0] clen;
    logic has_lc;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic busy;
    logic err_cmd;
    logic err_tlv;
    logic more;
    logic proact;
    logic resend;
    logic card_abort;
    logic [1:0] pend_sess;
    logic [15:0] rdata;
  } sbts_host_s;

  sbts_host_s q;
  sbts_host_s next_q;
  sbts_pkg::sbts_sess_s sess_q;
  sbts_pkg::sbts_sess_s mem_wd;
  logic mem_we;
  logic rx_clear;
  logic tlv_err;
  logic [7:0] rx_cnt;
  logic [7:0] rx_last;
  logic refuse;
  logic nomem;
  logic [15:0] status;

  // per-session remaining count, tag and pending flag
  sbts_sess_mem u_mem (
    .clock(clock),
    .rst(rst),
    .we(mem_we),
    .waddr(q.sess),
    .wdata(mem_wd),
    .raddr(q.sess),
    .rdata(sess_q)
  );

  // response tlv framing check
  sbts_tlv_rx u_rx (
    .clock(clock),
    .rst(rst),
    .clear(rx_clear),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .tag_err(tlv_err),
    .cnt(rx_cnt),
    .last(rx_last)
  );

  // status word image for reads
  always_comb begin
    status = '0;
    status[sbts_pkg::S_BUSY] = q.busy;
    status[sbts_pkg::S_ERR_CMD] = q.err_cmd;
    status[sbts_pkg::S_ERR_TLV] = q.err_tlv;
    status[sbts_pkg::S_MORE] = q.more;
    status[sbts_pkg::S_PROACT] = q.proact;
    status[sbts_pkg::S_RESEND] = q.resend;
    status[sbts_pkg::S_CARD_ABORT] = q.card_abort;
    status[sbts_pkg::S_PEND_LO +: 2] = q.pend_sess;
  end

  // command sequencing, status decoding and register port
  always_comb begin
    next_q = q;
    next_q.cmd_start = 1'b0;
    next_q.tx_valid = 1'b0;
    next_q.rdata = '0;
    mem_we = 1'b0;
    mem_wd = '0;
    rx_clear = 1'b0;
    nomem = ({rsp_sw1, rsp_sw2} == sbts_pkg::SW_NOMEM);
    refuse = 1'b0;
    // sticky flags clear on written ones; sets below win
    if (we && addr == sbts_pkg::A_STATUS) begin
      next_q.err_cmd = q.err_cmd & ~wdata[sbts_pkg::S_ERR_CMD];
      next_q.err_tlv = q.err_tlv & ~wdata[sbts_pkg::S_ERR_TLV];
      next_q.proact = q.proact & ~wdata[sbts_pkg::S_PROACT];
      next_q.card_abort = q.card_abort & ~wdata[sbts_pkg::S_CARD_ABORT];
    end
    if (we && !q.busy && addr == sbts_pkg::A_BLOCKS) begin
      next_q.blocks = wdata[7:0];
    end
    if (we && !q.busy && addr == sbts_pkg::A_LEN) begin
      next_q.len = wdata[7:0];
    end
    unique case (q.st)
      sbts_pkg::ST_IDLE: begin
        if (we && addr == sbts_pkg::A_CTRL) begin
          next_q.sess = wdata[sbts_pkg::C_SESS_LO +: 2];
          next_q.dir = wdata[sbts_pkg::C_DIR];
          next_q.abrt = wdata[sbts_pkg::C_ABORT];
          next_q.rtx = wdata[sbts_pkg::C_RTX];
          next_q.busy = 1'b1;
          next_q.st = sbts_pkg::ST_LOOK;
        end
      end
      sbts_pkg::ST_LOOK: begin
        next_q.st = sbts_pkg::ST_CHECK; // session entry read
      end
      sbts_pkg::ST_CHECK: begin
        refuse = (!q.abrt && !q.dir && q.blocks != 8'h00)
          || (!q.abrt && q.dir && sess_q.active && sess_q.remaining == 8'h00
              && sess_q.pending)
          || (sess_q.active && sess_q.tag != sbts_pkg::TAG_SCD);
        if (refuse) begin
          next_q.err_cmd = 1'b1;
          next_q.busy = 1'b0;
          next_q.st = sbts_pkg::ST_IDLE;
        end else begin
          next_q.cmd_start = 1'b1;
          next_q.p1 = '0;
          next_q.p1[sbts_pkg::P1_SESS_LO +: 2] = q.sess;
          next_q.p1[sbts_pkg::P1_DATA] = q.dir & ~q.abrt;
          next_q.p1[sbts_pkg::P1_ABORT] = q.abrt;
          next_q.p1[sbts_pkg::P1_RTX] = q.rtx & ~q.dir & ~q.abrt;
          next_q.p2 = q.blocks;
          next_q.cnt = 8'h00;
          rx_clear = 1'b1;
          if (q.abrt) begin
            next_q.has_lc = 1'b0;
            next_q.clen = 9'h000;
            next_q.st = sbts_pkg::ST_WAIT;
          end else if (q.dir) begin
            next_q.has_lc = 1'b1;
            next_q.clen = 9'h001 + {7'h00, sbts_pkg::sbts_len_hdr(q.len)} + {1'b0, q.len};
            next_q.st = sbts_pkg::ST_TAG;
          end else begin
            next_q.has_lc = 1'b0;
            next_q.clen = {1'b0, q.len};
            next_q.st = sbts_pkg::ST_WAIT;
          end
        end
      end
      sbts_pkg::ST_TAG: begin
        next_q.tx_valid = 1'b1;
        next_q.tx_byte = sbts_pkg::TAG_SCD;
        next_q.st = (sbts_pkg::sbts_len_hdr(q.len) == 2'h2) ? sbts_pkg::ST_LEXT : sbts_pkg::ST_LEN;
      end
      sbts_pkg::ST_LEXT: begin
        next_q.tx_valid = 1'b1;
        next_q.tx_byte = sbts_pkg::LEN_EXT;
        next_q.st = sbts_pkg::ST_LEN;
      end
      sbts_pkg::ST_LEN: begin
        next_q.tx_valid = 1'b1;
        next_q.tx_byte = q.len;
        next_q.st = (q.len == 8'h00) ? sbts_pkg::ST_WAIT : sbts_pkg::ST_VAL;
      end
      sbts_pkg::ST_VAL: begin
        if (we && addr == sbts_pkg::A_TXDATA) begin
          next_q.tx_valid = 1'b1;
          next_q.tx_byte = wdata[7:0];
          next_q.cnt = q.cnt + 8'h01;
          if (q.cnt + 8'h01 == q.len) begin
            next_q.st = sbts_pkg::ST_WAIT;
          end
        end
      end
      sbts_pkg::ST_WAIT: begin
        if (rsp_valid) begin
          next_q.sw1 = rsp_sw1;
          next_q.sw2 = rsp_sw2;
          next_q.busy = 1'b0;
          next_q.st = sbts_pkg::ST_IDLE;
          // framing judged once per answer, so a software clear sticks
          next_q.err_tlv = next_q.err_tlv | tlv_err;
          if (q.abrt || nomem) begin
            mem_we = 1'b1; // session data dropped
            next_q.more = 1'b0;
            next_q.card_abort = next_q.card_abort | (nomem & ~q.abrt);
          end else if (rsp_sw1 == sbts_pkg::SW1_ONGOING) begin
            mem_we = 1'b1;
            mem_wd.active = rsp_sw2[sbts_pkg::SW2_MORE] | (q.blocks != 8'h00);
            mem_wd.pending = rsp_sw2[sbts_pkg::SW2_MORE];
            mem_wd.tag = sbts_pkg::TAG_SCD;
            mem_wd.remaining = q.blocks;
            next_q.more = rsp_sw2[sbts_pkg::SW2_MORE];
            next_q.proact = next_q.proact | rsp_sw2[sbts_pkg::SW2_PRO];
            next_q.resend = rsp_sw2[sbts_pkg::SW2_RTX];
            next_q.pend_sess = rsp_sw2[sbts_pkg::SW2_SESS_LO +: 2];
          end else if (rsp_sw1 == sbts_pkg::SW1_PROACT) begin
            next_q.proact = 1'b1; // session entry untouched
          end
        end
      end
    endcase
    // read data stand in the cycle after the strobe
    if (re) begin
      unique case (addr)
        sbts_pkg::A_CTRL: next_q.rdata = {11'h000, q.rtx, q.abrt, q.dir, q.sess};
        sbts_pkg::A_BLOCKS: next_q.rdata = {8'h00, q.blocks};
        sbts_pkg::A_LEN: next_q.rdata = {8'h00, q.len};
        sbts_pkg::A_STATUS: next_q.rdata = status;
        sbts_pkg::A_SW: next_q.rdata = {q.sw1, q.sw2};
        sbts_pkg::A_RXDATA: next_q.rdata = {rx_cnt, rx_last};
        sbts_pkg::A_SESS: next_q.rdata = {6'h00, sess_q.active, sess_q.pending, sess_q.remaining};
        default: next_q.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign rdata = q.rdata;
  assign cmd_start = q.cmd_start;
  assign cmd_p1 = q.p1;
  assign cmd_p2 = q.p2;
  assign cmd_len = q.clen;
  assign cmd_has_lc = q.has_lc;
  assign tx_valid = q.tx_valid;
  assign tx_byte = q.tx_byte;

  // checks on the command stream and status decoding
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_long_len;
    tx_valid && tx_byte == sbts_pkg::TAG_SCD ##1 tx_valid && tx_byte == sbts_pkg::LEN_EXT
      ##1 tx_valid && tx_byte == $past(q.len);
  endsequence

  sequence s_ongoing_rsp;
    q.st == sbts_pkg::ST_WAIT && rsp_valid && !q.abrt && rsp_sw1 == sbts_pkg::SW1_ONGOING;
  endsequence

  a_session_field: assert property (
    cmd_start |-> cmd_p1[7:6] == q.sess && cmd_p1[5:3] == 3'h0)
    else $error("session field or reserved bits wrong");
  a_abort_no_data: assert property (
    cmd_start && cmd_p1[sbts_pkg::P1_ABORT] |-> !cmd_has_lc && cmd_len == 9'h000 && !cmd_p1[sbts_pkg::P1_DATA])
    else $error("abort command carries a length");
  a_data_no_rtx: assert property (
    cmd_start && cmd_p1[sbts_pkg::P1_DATA] |-> !cmd_p1[sbts_pkg::P1_RTX] && cmd_has_lc)
    else $error("retransmit set beside command data");
  a_blocks_need_data: assert property (
    cmd_start && cmd_p2 != 8'h00 |-> cmd_has_lc || cmd_p1[sbts_pkg::P1_ABORT])
    else $error("remaining blocks without data");
  a_tag_first: assert property (
    cmd_start && cmd_has_lc |=> tx_valid && tx_byte == sbts_pkg::TAG_SCD)
    else $error("tlv tag missing after command start");
  a_long_length: assert property (
    cmd_start && cmd_has_lc && q.len > sbts_pkg::LEN_SHORT_MAX |=> s_long_len)
    else $error("two byte length framing wrong");
  a_lc_total: assert property (
    cmd_start && cmd_has_lc |-> cmd_len == 9'h002 + {1'b0, q.len} + {8'h00, q.len > sbts_pkg::LEN_SHORT_MAX})
    else $error("command length does not match tlv size");
  a_more_flag: assert property (
    s_ongoing_rsp |=> q.more == $past(rsp_sw2[0]) && q.pend_sess == $past(rsp_sw2[2:1]) && !q.busy)
    else $error("more or pending session not taken from status");
  a_proact_flag: assert property (
    s_ongoing_rsp and rsp_sw2[sbts_pkg::SW2_PRO] |=> q.proact)
    else $error("proactive flag not raised");
  a_refuse_quiet: assert property (
    q.st == sbts_pkg::ST_CHECK && refuse |=> !cmd_start && q.err_cmd && !q.busy)
    else $error("refused command still started");
  a_abort_drops: assert property (
    q.st == sbts_pkg::ST_WAIT && rsp_valid && q.abrt |=> !q.more ##2 !sess_q.active && !sess_q.pending)
    else $error("terminal abort left session data");
  a_card_abort: assert property (
    q.st == sbts_pkg::ST_WAIT && rsp_valid && !q.abrt && {rsp_sw1, rsp_sw2} == sbts_pkg::SW_NOMEM
      |=> q.card_abort ##2 !sess_q.active)
    else $error("memory full status did not abort session");

endmodule : sbts_host

// ==== tb/sbts_card_model.sv ====
/*
  card-side model: counts command bytes, streams a short tlv answer on reads,
  then returns the status words chosen by the bench knobs.
  assumes one clock shared with the controller and a synchronous reset.
*/
`timescale 1ns/100ps
module sbts_card_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_p1,
  input wire logic [8:0] cmd_len,
  input wire logic cmd_has_lc,
  input wire logic tx_valid,
  input wire logic [7:0] ans_sw1,
  input wire logic [4:0] ans_flags, // slow, bad tag, resend, proactive, more
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rsp_valid,
  output logic [7:0] rsp_sw1,
  output logic [7:0] rsp_sw2
);
  int need;
  int sent;
  int wt;
  logic busy;

  // released lines toggle so stale values are never mistaken for answers
  always @(posedge clock) begin
    rx_valid <= 1'b0;
    rsp_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rsp_sw1 <= ~rsp_sw1;
    rsp_sw2 <= ~rsp_sw2;
    if (rst) begin
      busy <= 1'b0;
      rx_byte <= 8'h00;
      rsp_sw1 <= 8'h00;
      rsp_sw2 <= 8'h00;
    end else if (cmd_start) begin
      busy <= 1'b1;
      need <= cmd_has_lc ? int'(cmd_len) : 0;
      sent <= (cmd_has_lc || cmd_len == 9'h000) ? 3 : 0;
      wt <= ans_flags[4] ? 20 : 0;
    end else if (busy && tx_valid) begin
      need <= need - 1;
    end else if (busy && need == 0 && sent < 3) begin
      rx_valid <= 1'b1;
      rx_byte <= (sent == 0) ? (ans_flags[3] ? 8'h73 : 8'h80) : (sent == 1) ? 8'h01 : 8'h3c;
      sent <= sent + 1;
    end else if (busy && need == 0 && wt > 0) begin
      wt <= wt - 1;
    end else if (busy && need == 0) begin
      busy <= 1'b0;
      rsp_valid <= 1'b1;
      rsp_sw1 <= ans_sw1;
      rsp_sw2 <= (ans_sw1 == 8'h6a) ? 8'h84 : {3'h0, ans_flags[2:1], cmd_p1[7:6], ans_flags[0]};
    end
  end
endmodule : sbts_card_model

// ==== tb/test_secure_block_transfer_sessions.sv ====
/*
  self-checking bench of the session controller facing the card model.
  assumes the design package, design modules and card model compile first.
*/
`timescale 1ns/100ps
module test_secure_block_transfer_sessions;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] ans_sw1 = 8'h92;
  logic [4:0] ans_flags = 5'h00;
  logic [15:0] rdata;
  logic cmd_start, cmd_has_lc, tx_valid, rx_valid, rsp_valid;
  logic [7:0] cmd_p1, cmd_p2, tx_byte, rx_byte, rsp_sw1, rsp_sw2;
  logic [8:0] cmd_len;
  logic [25:0] hdr;
  logic [7:0] txq[$];
  int n_cmd = 0;
  int n_mismatch = 0;
  int num_checks = 0;

  sbts_host uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
    .cmd_start(cmd_start), .cmd_p1(cmd_p1), .cmd_p2(cmd_p2), .cmd_len(cmd_len), .cmd_has_lc(cmd_has_lc),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rsp_valid(rsp_valid), .rsp_sw1(rsp_sw1), .rsp_sw2(rsp_sw2));

  sbts_card_model card (.clock(clock), .rst(rst), .cmd_start(cmd_start), .cmd_p1(cmd_p1), .cmd_len(cmd_len),
    .cmd_has_lc(cmd_has_lc), .tx_valid(tx_valid), .ans_sw1(ans_sw1), .ans_flags(ans_flags),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rsp_valid(rsp_valid), .rsp_sw1(rsp_sw1), .rsp_sw2(rsp_sw2));

  // clock generator, 50 ns period
  initial begin
    forever #25 clock = ~clock;
  end

  // records each command header and every byte the controller puts on the link
  always @(posedge clock) begin
    if (cmd_start === 1'b1) begin
      n_cmd <= n_cmd + 1;
      hdr <= {cmd_p1, cmd_p2, cmd_has_lc, cmd_len};
    end
    if (tx_valid === 1'b1) begin
      txq.push_back(tx_byte);
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clock);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    re <= 1'b1;
    @(posedge clock);
    re <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk($sformatf("register %h", a), {16'h0, e}, {16'h0, v & m});
  endtask : rchk

  // sets the card's answer, issues one command, feeds value bytes, waits for idle
  task automatic cmd(input logic [15:0] ctl, input logic [7:0] blk, input logic [7:0] len, input int n,
                     input logic [7:0] sw1, input logic [4:0] fl);
    logic [15:0] s;
    @(posedge clock);
    ans_sw1 <= sw1;
    ans_flags <= fl;
    txq.delete();
    wr(sbts_pkg::A_BLOCKS, {8'h00, blk});
    wr(sbts_pkg::A_LEN, {8'h00, len});
    wr(sbts_pkg::A_CTRL, ctl);
    repeat (6) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      wr(sbts_pkg::A_TXDATA, {8'h00, 8'(i * 7 + 3)});
    end
    s = 16'h0001;
    for (int i = 0; i < 200 && s[0] !== 1'b0; i++) begin
      rd(sbts_pkg::A_STATUS, s);
    end
    chk("busy", 32'h0, {31'h0, s[0]});
  endtask : cmd

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rchk(sbts_pkg::A_STATUS, 16'hffff, 16'h0000);
    wr(8'h22, 16'hffff);
    rchk(8'h22, 16'hffff, 16'h0000);
    // data block in session 2, resend bit must be dropped, card flags proactive and more
    cmd(16'h0016, 8'h01, 8'h02, 2, 8'h92, 5'h03);
    chk("header", {8'h84, 8'h01, 1'b1, 9'd4}, hdr);
    chk("tx stream", 32'h8002030a, {txq[0], txq[1], txq[2], txq[3]});
    rchk(sbts_pkg::A_SW, 16'hffff, 16'h920d);
    rchk(sbts_pkg::A_STATUS, 16'h01ff, 16'h0118);
    rchk(sbts_pkg::A_SESS, 16'h03ff, 16'h0301);
    // no data but blocks still to send is refused
    cmd(16'h0000, 8'h01, 8'h04, 0, 8'h92, 5'h00);
    chk("commands", 32'd1, n_cmd);
    rchk(sbts_pkg::A_STATUS, 16'h0002, 16'h0002);
    wr(sbts_pkg::A_STATUS, 16'h0056);
    // terminal abort of session 2 drops its state
    cmd(16'h000a, 8'h00, 8'h00, 0, 8'h92, 5'h00);
    chk("abort header", {8'h82, 8'h00, 1'b0, 9'd0}, hdr);
    rchk(sbts_pkg::A_SESS, 16'h03ff, 16'h0000);
    // final long block in session 1 with a slow card
    cmd(16'h0005, 8'h00, 8'hc8, 200, 8'h92, 5'h10);
    chk("long header", {8'h44, 8'h00, 1'b1, 9'd203}, hdr);
    chk("long stream", {8'h80, 8'h81, 8'hc8, 8'h74}, {txq[0], txq[1], txq[2], txq[202]});
    chk("long count", 32'd203, txq.size());
    rchk(sbts_pkg::A_SW, 16'hffff, 16'h9202);
    rchk(sbts_pkg::A_SESS, 16'h03ff, 16'h0000);
    // read in session 3, card has more blocks
    cmd(16'h0003, 8'h00, 8'h03, 0, 8'h92, 5'h01);
    chk("read header", {8'hc0, 8'h00, 1'b0, 9'd3}, hdr);
    rchk(sbts_pkg::A_RXDATA, 16'h00ff, 16'h003c);
    rchk(sbts_pkg::A_STATUS, 16'h0004, 16'h0000);
    rchk(sbts_pkg::A_SW, 16'hffff, 16'h9207);
    rchk(sbts_pkg::A_SESS, 16'h03ff, 16'h0300);
    // new data while the card still answers is refused
    cmd(16'h0007, 8'h00, 8'h02, 0, 8'h92, 5'h00);
    chk("commands", 32'd4, n_cmd);
    rchk(sbts_pkg::A_STATUS, 16'h0002, 16'h0002);
    wr(sbts_pkg::A_STATUS, 16'h0056);
    // resend request in session 3, card asks for resend too
    cmd(16'h0013, 8'h00, 8'h03, 0, 8'h92, 5'h04);
    chk("resend header", {8'hc1, 8'h00, 1'b0, 9'd3}, hdr);
    rchk(sbts_pkg::A_SW, 16'hffff, 16'h9216);
    rchk(sbts_pkg::A_STATUS, 16'h0020, 16'h0020);
    // session 0 read answered with proactive status and a foreign tag
    cmd(16'h0000, 8'h00, 8'h03, 0, 8'h91, 5'h08);
    rchk(sbts_pkg::A_STATUS, 16'h0014, 16'h0014);
    wr(sbts_pkg::A_STATUS, 16'h0056);
    rchk(sbts_pkg::A_STATUS, 16'h0014, 16'h0000);
    // card runs out of memory during a read in session 3 and aborts it
    cmd(16'h0003, 8'h00, 8'h03, 0, 8'h6a, 5'h00);
    rchk(sbts_pkg::A_SW, 16'hffff, 16'h6a84);
    rchk(sbts_pkg::A_STATUS, 16'h0040, 16'h0040);
    rchk(sbts_pkg::A_SESS, 16'h03ff, 16'h0000);
    test_done();
  end
endmodule : test_secure_block_transfer_sessions
